// ===== verilog/exception_priority_arbiter.sv
// Exception priority arbiter: resolves pending exceptions to one winner per cycle.
// Assumes request inputs are synchronous to sys_clk and held by their sources until taken.
// Contract
// - Of simultaneous pending exceptions only the highest effective priority is presented.
// - Reset sources fixed at -3, non-maskable sources fixed at -2.
// - Hard fault fixed at -1, raised for nested or disabled faults.
// - Memory, bus and usage fault classes each have their own enable.
// - A fault of a disabled class escalates to hard fault.
// - Number 4 raised by fetch from the execute-never region.
// - Number 5 raised by bus violation, configurable priority.
// - Number 6 raised by undefined or faulting instruction, configurable priority.
// - Number 11 raised by supervisor call, configurable priority.
// - Number 12 debug monitor only when not faulting; 7-10 and 13 reserved.
// - Number 14 pendable service request, 15 tick event, both configurable.
// - Numbers from 16 upward are external interrupts, each configurable.
// - Configurable exceptions take software priority; fixed ones ignore programming.
// - External priorities from priority registers, others from handler priority register.
// - Smaller programmable value wins; zero is highest.
// - Equal priority resolves to the smaller exception number.
// - Each handler priority field is three bits wide.
// - Split setting divides each field into pre-emption and sub-priority.
// - Compare pre-emption first, then sub-priority, then exception number.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none

module exception_priority_arbiter
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sources
  input wire exc_arb_pkg::sys_req_s sys_req,
  input wire logic [exc_arb_pkg::NUM_EXT-1:0] ext_irq,
  // Core side
  output logic exc_valid,
  output logic [7:0] exc_number,
  output logic exc_escalated,
  input wire logic exc_ack
);

  // Software-visible state
  logic [31:0] ctrl;
  logic [31:0] shpr;
  logic [31:0] ipr0;
  logic [31:0] ipr1;
  exc_arb_pkg::winner_s win_q;
  logic rd_pending;

  // Control fields
  wire mem_en = ctrl[exc_arb_pkg::CTRL_MEM_EN];
  wire bus_en = ctrl[exc_arb_pkg::CTRL_BUS_EN];
  wire usage_en = ctrl[exc_arb_pkg::CTRL_USAGE_EN];
  wire [2:0] priority_group_split = ctrl[exc_arb_pkg::CTRL_SPLIT_LSB +: 3];

  // Bus decode
  wire sel_ctrl = avs_address == exc_arb_pkg::OFS_CTRL;
  wire sel_shpr = avs_address == exc_arb_pkg::OFS_SHPR;
  wire sel_ipr0 = avs_address == exc_arb_pkg::OFS_IPR0;
  wire sel_ipr1 = avs_address == exc_arb_pkg::OFS_IPR1;
  wire sel_stat = avs_address == exc_arb_pkg::OFS_STAT;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire wr_ctrl = avs_write && sel_ctrl;
  wire wr_shpr = avs_write && sel_shpr;
  wire wr_ipr0 = avs_write && sel_ipr0;
  wire wr_ipr1 = avs_write && sel_ipr1;

  // Only 3 bits of each nibble are kept, so reads of the top bit return zero
  localparam logic [31:0] PRI_KEEP = 32'h7777_7777;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] be, input logic [31:0] keep);
    merge = ((old & ~be) | (wd & be)) & keep;
  endfunction : merge

  wire [31:0] stat_word = {15'h0000, win_q.escalated, 7'h00, win_q.valid, win_q.number};

  wire [31:0] next_readdata = sel_ctrl ? ctrl :
                              sel_shpr ? shpr :
                              sel_ipr0 ? ipr0 :
                              sel_ipr1 ? ipr1 :
                              sel_stat ? stat_word : exc_arb_pkg::UNMAPPED_DATA;

  // Reads take one wait cycle so read data come from a flop; writes finish at once
  wire rd_start = avs_read && !rd_pending;
  assign avs_waitrequest = rd_start;

  // Fault class enables and the priority group split
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl <= exc_arb_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= merge(ctrl, avs_writedata, be_mask, exc_arb_pkg::CTRL_MASK);
  end

  // Handler priority fields, one nibble per configurable system exception
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      shpr <= 32'h0000_0000;
    else if (wr_shpr)
      shpr <= merge(shpr, avs_writedata, be_mask, PRI_KEEP);
  end

  // External line priorities, lines 0 to 7
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ipr0 <= 32'h0000_0000;
    else if (wr_ipr0)
      ipr0 <= merge(ipr0, avs_writedata, be_mask, PRI_KEEP);
  end

  // External line priorities, lines 8 to 15
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ipr1 <= 32'h0000_0000;
    else if (wr_ipr1)
      ipr1 <= merge(ipr1, avs_writedata, be_mask, PRI_KEEP);
  end

  // A held read toggles this, so a master that keeps read high starts a fresh access
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_pending <= 1'b0;
    else
      rd_pending <= rd_start;
  end

  // Data loaded in the first read cycle stand at the edge that ends the wait
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (rd_start)
      avs_readdata <= next_readdata;
  end

  // Fault classification
  wire mem_raw = sys_req.fetch_execute_never_region;
  wire bus_raw = sys_req.bus_violation;
  wire usage_raw = sys_req.usage_fault;
  wire mem_go = mem_raw && mem_en;
  wire bus_go = bus_raw && bus_en;
  wire usage_go = usage_raw && usage_en;
  wire escalate = (mem_raw && !mem_en) || (bus_raw && !bus_en) ||
                  (usage_raw && !usage_en);
  wire hard_req = sys_req.fault_nested || escalate;
  wire reset_req = sys_req.reset_pin || sys_req.reset_wdt ||
                   sys_req.software_system_reset_request;
  wire nmi_req = sys_req.nmi_pin || sys_req.nmi_wdt;
  wire faulting = hard_req || mem_raw || bus_raw || usage_raw;
  wire debug_go = sys_req.debug_mon && !faulting;

  // Configurable slots: 0..6 system handlers, 7.. external lines
  // Nets, since the slots are driven by several separate assignments (slots 0..6 of cfg_req share one)
  wire [exc_arb_pkg::NUM_CFG-1:0] cfg_req;
  wire [exc_arb_pkg::NUM_CFG-1:0][7:0] cfg_num;
  wire [exc_arb_pkg::NUM_CFG-1:0][2:0] cfg_pri;
  wire [63:0] ipr_all = {ipr1, ipr0};

  // System handler fields sit one per nibble of the handler priority register
  assign cfg_req[6:0] = {sys_req.system_tick_timer_event, sys_req.pendable_service_request,
                         debug_go, sys_req.supervisor_call_exception,
                         usage_go, bus_go, mem_go};
  assign cfg_num[0] = exc_arb_pkg::EXC_MEM;
  assign cfg_num[1] = exc_arb_pkg::EXC_BUS;
  assign cfg_num[2] = exc_arb_pkg::EXC_USAGE;
  assign cfg_num[3] = exc_arb_pkg::EXC_SVC;
  assign cfg_num[4] = exc_arb_pkg::EXC_DEBUG;
  assign cfg_num[5] = exc_arb_pkg::EXC_PEND;
  assign cfg_num[6] = exc_arb_pkg::EXC_TICK;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sys
      assign cfg_pri[gi] = shpr[gi*4 +: 3];
    end
    for (gi = 0; gi < exc_arb_pkg::NUM_EXT; gi++)
    begin : g_ext
      assign cfg_req[7+gi] = ext_irq[gi];
      assign cfg_num[7+gi] = exc_arb_pkg::EXC_EXT0 + 8'(gi);
      assign cfg_pri[7+gi] = ipr_all[gi*4 +: 3];
    end
  endgenerate

  // Split 0 keeps all three bits as pre-emption; 1 and 2 move one or two low bits
  // into the sub-priority; 3 and above leave no pre-emption bits. Pre sits above sub
  // in the rank word, so one compare orders pre-emption first.
  function automatic logic [5:0] rank(input logic [2:0] pri, input logic [2:0] sp);
    logic [2:0] pre;
    logic [2:0] sub;
    pre = 3'h0;
    sub = 3'h0;
    unique case (sp)
      3'h0:
      begin
        pre = pri;
        sub = 3'h0;
      end
      3'h1:
      begin
        pre = {1'b0, pri[2:1]};
        sub = {2'b00, pri[0]};
      end
      3'h2:
      begin
        pre = {2'b00, pri[2]};
        sub = {1'b0, pri[1:0]};
      end
      default:
      begin
        pre = 3'h0;
        sub = pri;
      end
    endcase
    rank = {pre, sub};
  endfunction : rank

  // Scan chain in exception number order: stage i+1 holds the best of slots 0 to i.
  // Strict less-than keeps the earlier, smaller number on a tie.
  wire [exc_arb_pkg::NUM_CFG:0] scan_any;
  wire [exc_arb_pkg::NUM_CFG:0][7:0] scan_num;
  wire [exc_arb_pkg::NUM_CFG:0][5:0] scan_rank;
  assign scan_any[0] = 1'b0;
  assign scan_num[0] = exc_arb_pkg::EXC_NONE;
  assign scan_rank[0] = 6'h3f;

  generate
    for (gi = 0; gi < exc_arb_pkg::NUM_CFG; gi++)
    begin : g_scan
      wire [5:0] slot_rank = rank(cfg_pri[gi], priority_group_split);
      wire slot_wins = cfg_req[gi] &&
                       (!scan_any[gi] || slot_rank < scan_rank[gi]);
      assign scan_any[gi+1] = scan_any[gi] || cfg_req[gi];
      assign scan_num[gi+1] = slot_wins ? cfg_num[gi] : scan_num[gi];
      assign scan_rank[gi+1] = slot_wins ? slot_rank : scan_rank[gi];
    end
  endgenerate

  wire cfg_any = scan_any[exc_arb_pkg::NUM_CFG];
  wire [7:0] cfg_best_num = scan_num[exc_arb_pkg::NUM_CFG];

  // Fixed levels checked first so no programmed value can beat them
  exc_arb_pkg::winner_s next_win;
  always_comb
  begin
    next_win.valid = 1'b1;
    next_win.escalated = 1'b0;
    if (reset_req)
      next_win.number = exc_arb_pkg::EXC_RESET;
    else if (nmi_req)
      next_win.number = exc_arb_pkg::EXC_NMI;
    else if (hard_req)
    begin
      next_win.number = exc_arb_pkg::EXC_HARD;
      next_win.escalated = escalate;
    end
    else if (cfg_any)
      next_win.number = cfg_best_num;
    else
    begin
      next_win.valid = 1'b0;
      next_win.number = exc_arb_pkg::EXC_NONE;
    end
  end

  // Winner is re-evaluated every cycle; ack drops the presented one for a cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      win_q <= '0;
    else if (exc_ack && win_q.valid)
      win_q <= '0;
    else
      win_q <= next_win;
  end

  assign exc_valid = win_q.valid;
  assign exc_number = win_q.number;
  assign exc_escalated = win_q.escalated;

endmodule : exception_priority_arbiter

`default_nettype wire

// ===== verilog/exc_arb_pkg.sv
// Package for the exception priority arbiter: exception numbers, register map, field layout.
// Assumes one 250 MHz clock domain and an Avalon-MM slave port with 32-bit data.
`default_nettype none
package exc_arb_pkg;

  // Exception numbers
  localparam logic [7:0] EXC_RESET = 8'h01;
  localparam logic [7:0] EXC_NMI = 8'h02;
  localparam logic [7:0] EXC_HARD = 8'h03;
  localparam logic [7:0] EXC_MEM = 8'h04;
  localparam logic [7:0] EXC_BUS = 8'h05;
  localparam logic [7:0] EXC_USAGE = 8'h06;
  localparam logic [7:0] EXC_SVC = 8'h0b;
  localparam logic [7:0] EXC_DEBUG = 8'h0c;
  localparam logic [7:0] EXC_PEND = 8'h0e;
  localparam logic [7:0] EXC_TICK = 8'h0f;
  localparam logic [7:0] EXC_EXT0 = 8'h10;
  localparam logic [7:0] EXC_NONE = 8'h00;

  // Sizes
  localparam int NUM_EXT = 16;
  localparam int PRI_W = 3;
  localparam int NUM_CFG = 7 + NUM_EXT;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SHPR = 6'h04;
  localparam logic [5:0] OFS_IPR0 = 6'h08;
  localparam logic [5:0] OFS_IPR1 = 6'h0c;
  localparam logic [5:0] OFS_STAT = 6'h10;

  // Control register fields
  localparam int CTRL_MEM_EN = 0;
  localparam int CTRL_BUS_EN = 1;
  localparam int CTRL_USAGE_EN = 2;
  localparam int CTRL_SPLIT_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0707;

  // Answer to an unmapped read
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic reset_pin;
    logic reset_wdt;
    logic software_system_reset_request;
    logic nmi_pin;
    logic nmi_wdt;
    logic fault_nested;
    logic fetch_execute_never_region;
    logic bus_violation;
    logic usage_fault;
    logic supervisor_call_exception;
    logic debug_mon;
    logic pendable_service_request;
    logic system_tick_timer_event;
  } sys_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] number;
    logic escalated;
  } winner_s;

endpackage : exc_arb_pkg

`default_nettype wire

// ===== tb/exc_arb_assertions.sv
// Checker for the exception arbiter, bound to its top ports.
// Assumes the core never holds exc_ack for two cycles in a row.
`timescale 1ns/1ns
`default_nettype none
module exc_arb_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sources and core side
  input wire exc_arb_pkg::sys_req_s sys_req,
  input wire logic [exc_arb_pkg::NUM_EXT-1:0] ext_irq,
  input wire logic exc_valid,
  input wire logic [7:0] exc_number,
  input wire logic exc_escalated,
  input wire logic exc_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rst_any = sys_req.reset_pin | sys_req.reset_wdt | sys_req.software_system_reset_request;
  wire nmi_any = sys_req.nmi_pin | sys_req.nmi_wdt;
  wire flt = sys_req.fetch_execute_never_region | sys_req.bus_violation | sys_req.usage_fault;
  sequence s_fixed;
    (rst_any | nmi_any | sys_req.fault_nested) && !exc_ack;
  endsequence
  sequence s_ext_only;
    sys_req == '0 && ext_irq != '0 && !exc_ack;
  endsequence
  AST_RESET_TOP: assert property (rst_any && !exc_ack |=> exc_valid && exc_number == 8'h01)
    else $error("reset not chosen");
  AST_NMI: assert property (nmi_any && !rst_any && !exc_ack |=> exc_number == 8'h02)
    else $error("nmi not chosen");
  AST_NESTED: assert property (sys_req.fault_nested && !rst_any && !nmi_any && !exc_ack
    |=> exc_number == 8'h03 && !exc_escalated) else $error("hard fault not chosen");
  AST_ESC: assert property (exc_escalated |-> exc_valid && exc_number == 8'h03)
    else $error("escalation not hard fault");
  AST_LEGAL: assert property (exc_valid |-> exc_number inside {[1:6], 11, 12, [14:31]})
    else $error("reserved number");
  AST_DEBUG: assert property (exc_valid && exc_number == 8'h0c |-> $past(!flt))
    else $error("debug while faulting");
  AST_EXT: assert property (s_ext_only |=> exc_valid && exc_number[7:4] == 4'h1)
    else $error("external not chosen");
  AST_FIXED: assert property (s_fixed |=> exc_valid && exc_number <= 8'h03)
    else $error("fixed outranked");
  AST_IDLE: assert property (sys_req == '0 && ext_irq == '0 |=> !exc_valid)
    else $error("winner without request");
  AST_ACK_DROP: assert property (exc_ack && exc_valid |=> !exc_valid)
    else $error("taken winner still presented");
endmodule : exc_arb_checker
bind exception_priority_arbiter exc_arb_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .sys_req(sys_req), .ext_irq(ext_irq), .exc_valid(exc_valid), .exc_number(exc_number),
  .exc_escalated(exc_escalated), .exc_ack(exc_ack));
`default_nettype wire

// ===== tb/core_model.sv
// Core model: takes the presented winner while allowed.
// Assumes exc_valid is registered on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module core_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Arbiter side
  input wire logic exc_valid,
  input wire logic take_en,
  output logic exc_ack
);
  // Pulse only: a held acknowledge would swallow the next winner unseen
  always_ff @(posedge sys_clk)
  begin
    exc_ack <= !rst && take_en && exc_valid && !exc_ack;
  end
endmodule : core_model
`default_nettype wire

// ===== tb/test_exception_priority_arbiter.sv
// Testbench for the exception arbiter: register setup, request patterns, random lines.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module test_exception_priority_arbiter;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q, rs = 32'hfbd7;
  logic avs_waitrequest, exc_valid, exc_escalated, exc_ack, take_en = 1'b0, take = 1'b0;
  exc_arb_pkg::sys_req_s sys_req = '0;
  logic [15:0] ext_irq = 16'h0;
  logic [7:0] exc_number;
  logic [9:0] exp_q[$];
  int bad_count = 0;
  int n_tests = 0;
  int i;
  exception_priority_arbiter dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sys_req(sys_req), .ext_irq(ext_irq), .exc_valid(exc_valid), .exc_number(exc_number),
    .exc_escalated(exc_escalated), .exc_ack(exc_ack));
  core_model partner (.sys_clk(sys_clk), .rst(rst), .exc_valid(exc_valid),
    .take_en(take_en), .exc_ack(exc_ack));
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [9:0] lowest(input logic [15:0] x);
    for (int b = 0; b < 16; b++)
      if (x[b])
        return {2'b01, 8'h10 + 8'(b)};
    return 10'h000;
  endfunction : lowest
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction : xorshift
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 20)
    begin
      bad_count++;
      results();
    end
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rd
  // Winner is registered one edge after the requests, so compare between edges
  task automatic ap(input logic [12:0] r, input logic [15:0] x, input logic [9:0] e);
    sys_req <= r;
    ext_irq <= x;
    exp_q.push_back(e);
    @(posedge sys_clk);
    take <= 1'b1;
    @(posedge sys_clk);
    take <= 1'b0;
  endtask : ap
  always @(negedge sys_clk)
    if (take)
      check({exc_escalated, exc_valid, exc_number}, exp_q.pop_front());
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b1, 6'h14, 32'hffff_ffff);
    rd(6'h14, 32'h0);
    rd(6'h00, 32'h0);
    ap(13'h1281, 16'hffff, 10'h101);
    for (i = 10; i < 13; i++)
      ap(13'h1 << i, 16'h0001, 10'h101);
    for (i = 8; i < 10; i++)
      ap((13'h1 << i) | 13'h0090, 16'h0, 10'h102);
    ap(13'h0088, 16'h0, 10'h103);
    for (i = 4; i < 7; i++)
      ap(13'h1 << i, 16'h0001, 10'h303);
    rd(6'h10, 32'h0001_0103);
    for (i = 0; i < 4; i++)
      ap(13'h1 << i, 16'h0, {2'b01, 8'(32'h0b0c0e0f >> (8 * i))});
    bus(1'b1, 6'h00, 32'hffff_ffff);
    rd(6'h00, 32'h0000_0707);
    bus(1'b1, 6'h00, 32'h0000_0007);
    for (i = 4; i < 7; i++)
      ap(13'h1 << i, 16'h0, {2'b01, 8'h0a - 8'(i)});
    ap(13'h0049, 16'h0, 10'h104);
    bus(1'b1, 6'h04, 32'h0ef8_9dab);
    rd(6'h04, 32'h0670_1523);
    ap(13'h0070, 16'h0, 10'h105);
    ap(13'h000b, 16'h0, 10'h10b);
    ap(13'h0014, 16'h0, 10'h106);
    ap(13'h0003, 16'h0, 10'h10f);
    bus(1'b1, 6'h08, 32'h0000_0447);
    ap(13'h0, 16'h0007, 10'h111);
    ap(13'h0008, 16'h0001, 10'h10b);
    ap(13'h0008, 16'h0008, 10'h113);
    ap(13'h0080, 16'h0008, 10'h103);
    bus(1'b1, 6'h00, 32'h0000_0207);
    ap(13'h0, 16'h0003, 10'h111);
    bus(1'b1, 6'h0c, 32'h0000_0001);
    ap(13'h0, 16'h0300, 10'h119);
    bus(1'b1, 6'h08, 32'h0);
    bus(1'b1, 6'h0c, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      rs = xorshift(rs);
      ap(13'h0, rs[15:0], lowest(rs[15:0]));
    end
    take_en <= 1'b1;
    repeat (6) @(posedge sys_clk);
    results();
  end
endmodule : test_exception_priority_arbiter
`default_nettype wire
